// ==== logic/sgc_host.sv ====
// Host controller that opens, closes and accesses the supervisor RAM gate.
// Operation
// - Host places the 2K window on a 2K boundary, at the top or bottom of the 64K segment.
// - Host toggles with three matching strobes, then enable high.
// - Host guarantees enable high at the end of each unlock cycle.
// - Small systems drive enable from an available strobe.
// - Host drives the match strobe from its own strobe timer, apart from its write strobe.
// - Other decodes are gated by the conditioned enable output.
// - Large systems hold enable low across the whole segment.
// - Shadowing: enable covers window and SRAM; output feeds SRAM.
// - With one SRAM, the conditioned output drives it directly.
`timescale 1ns/1ps
`include "sgc_cfg.svh"
module sgc_host #(
  parameter logic [15:0] UNLOCK_RESET = `SGC_UNLOCK_DEFAULT,
  parameter logic [3:0]  STROBE_CYC   = `SGC_STROBE_CYCLES,
  parameter logic [3:0]  ACCESS_CYC   = `SGC_ACCESS_CYCLES
) (
  // Clock and reset.
  input  wire  logic        MCLK,
  input  wire  logic        NRST,
  // User command port.
  input  wire  logic        REQ_TOGGLE,
  input  wire  logic        REQ_ACCESS,
  input  wire  logic        REQ_WRITE,
  input  wire  logic [15:0] REQ_ADDR,
  input  wire  logic [7:0]  REQ_WDATA,
  input  wire  logic        SET_TOP,
  input  wire  logic        SET_TOP_VAL,
  input  wire  logic        SET_UNLOCK,
  input  wire  logic [15:0] SET_UNLOCK_VAL,
  output logic              READY,
  output logic              DONE,
  output logic [7:0]        RDATA,
  output logic              WINDOW_OPEN,
  output logic              REFUSED,
  // Gate pins.
  output logic [15:0]       ADDR,
  output logic [7:0]        DATA_OUT,
  output logic              DATA_OE,
  input  wire  logic [7:0]  DATA_IN,
  output logic              CE_N,
  output logic              WE_N,
  output logic              OE_N,
  output logic              UNLOCK_MATCH_STROBE,
  input  wire  logic        CONDITIONED_ENABLE_OUT_N,
  // Decode enable for other devices in the segment.
  output logic              EXT_SELECT_N
);
  sgc_pkg::sgc_regs_t q, d;
  sgc_window_if win ();

  sgc_window_dec u_dec (
    .win (win)
  );

  assign win.addr = q.addr;
  assign win.top  = q.top;
  assign win.open = q.open;

  always_comb begin
    d      = q;
    d.done = 1'b0;
    case (q.state)
      sgc_pkg::SGC_IDLE: begin
        if (SET_UNLOCK) begin
          d.unlock = SET_UNLOCK_VAL;
        end
        if (SET_TOP) begin
          d.top = SET_TOP_VAL;
        end
        if (REQ_TOGGLE) begin
          // The address settles a gap ahead of the first strobe fall, so the capture is clean.
          d.addr    = d.unlock;
          d.wr      = 1'b1;
          d.strobes = 2'h0;
          d.timer   = `SGC_GAP_CYCLES;
          d.state   = sgc_pkg::SGC_GAP;
        end else if (REQ_ACCESS) begin
          d.addr  = REQ_ADDR;
          d.wdata = REQ_WDATA;
          d.wr    = REQ_WRITE;
          d.state = sgc_pkg::SGC_ACCESS;
          d.timer = ACCESS_CYC;
        end
      end
      sgc_pkg::SGC_STROBE: begin
        d.timer = q.timer - 4'h1;
        if (q.timer == 4'h1) begin
          d.match_n = 1'b1;
          d.strobes = q.strobes + 2'h1;
          d.timer   = `SGC_GAP_CYCLES;
          d.state   = (q.strobes + 2'h1 == `SGC_MATCH_COUNT) ?
                      sgc_pkg::SGC_RELEASE : sgc_pkg::SGC_GAP;
        end
      end
      sgc_pkg::SGC_GAP: begin
        d.timer = q.timer - 4'h1;
        if (q.timer == 4'h1) begin
          d.match_n = 1'b0;
          d.timer   = STROBE_CYC;
          d.state   = sgc_pkg::SGC_STROBE;
        end
      end
      sgc_pkg::SGC_RELEASE: begin
        // Enable is high here, so the gate flips its state now.
        d.open  = !q.open;
        d.done  = 1'b1;
        d.state = sgc_pkg::SGC_IDLE;
      end
      sgc_pkg::SGC_ACCESS: begin
        d.ce_n  = 1'b0;
        // Write enable rises a cycle before chip enable, so the write never ends in a race.
        // This needs an access length of three cycles or more.
        d.we_n  = !q.wr || (q.timer == 4'h2);
        d.oe_n  = q.wr;
        d.timer = q.timer - 4'h1;
        if (q.timer == 4'h1) begin
          d.ce_n  = 1'b1;
          d.we_n  = 1'b1;
          d.oe_n  = 1'b1;
          d.rdata = DATA_IN;
          d.done  = 1'b1;
          d.state = sgc_pkg::SGC_IDLE;
        end
      end
      default: begin
        d.state = sgc_pkg::SGC_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      q.state   <= sgc_pkg::SGC_IDLE;
      q.timer   <= 4'h0;
      q.strobes <= 2'h0;
      q.addr    <= 16'h0000;
      q.wdata   <= 8'h00;
      q.wr      <= 1'b0;
      q.open    <= 1'b0;
      q.top     <= 1'b1;
      q.unlock  <= UNLOCK_RESET;
      q.ce_n    <= 1'b1;
      q.we_n    <= 1'b1;
      q.oe_n    <= 1'b1;
      q.match_n <= 1'b1;
      q.rdata   <= 8'h00;
      q.done    <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign READY               = q.state == sgc_pkg::SGC_IDLE;
  assign DONE                = q.done;
  assign RDATA               = q.rdata;
  assign WINDOW_OPEN         = q.open;
  // Accesses to the closed window reach the external memory instead.
  assign REFUSED             = win.in_window && !q.open;
  assign ADDR                = q.addr;
  assign DATA_OUT            = q.wdata;
  assign DATA_OE             = q.wr && (q.state == sgc_pkg::SGC_ACCESS);
  assign CE_N                = q.ce_n;
  assign WE_N                = q.we_n;
  assign OE_N                = q.oe_n;
  assign UNLOCK_MATCH_STROBE = q.match_n;
  assign EXT_SELECT_N        = CONDITIONED_ENABLE_OUT_N;

  a_toggle_flips: assert property (@(posedge MCLK) disable iff (!NRST)
    q.state == sgc_pkg::SGC_RELEASE |=> q.open != $past(q.open))
    else $error("window state did not flip after third strobe");
  a_three_strobes: assert property (@(posedge MCLK) disable iff (!NRST)
    $rose(q.state == sgc_pkg::SGC_RELEASE) |-> q.strobes == `SGC_MATCH_COUNT && q.ce_n)
    else $error("release without three strobes and enable high");
  a_enable_high_unlock: assert property (@(posedge MCLK) disable iff (!NRST)
    !q.match_n |-> q.ce_n)
    else $error("enable low during unlock strobe");
  a_strobe_addr: assert property (@(posedge MCLK) disable iff (!NRST)
    $fell(q.match_n) |-> q.addr == q.unlock)
    else $error("strobe with wrong address");
  a_ce_release: assert property (@(posedge MCLK) disable iff (!NRST)
    $fell(q.ce_n) |-> ##[1:15] q.ce_n)
    else $error("enable not released after access");
  a_closed_decode: assert property (@(posedge MCLK) disable iff (!NRST)
    !q.open |-> win.gate_ext)
    else $error("closed window blocks external memory");
  a_open_decode: assert property (@(posedge MCLK) disable iff (!NRST)
    q.open && win.in_window |-> !win.gate_ext)
    else $error("open window not served");
  a_done_pulse: assert property (@(posedge MCLK) disable iff (!NRST)
    q.done |=> !q.done)
    else $error("done longer than one cycle");
endmodule

// ==== logic/sgc_cfg.svh ====
// Constants for the supervisor RAM gate host controller.
`ifndef SGC_CFG_SVH
`define SGC_CFG_SVH
`define SGC_UNLOCK_DEFAULT 16'h07FF
`define SGC_WIN_TOP_BASE   16'hF800
`define SGC_WIN_BOT_BASE   16'h0000
`define SGC_WIN_MASK       16'hF800
`define SGC_REG_BASE       16'h07F8
`define SGC_REG_MASK       16'h07F8
`define SGC_MATCH_COUNT    2'h3
`define SGC_STROBE_CYCLES  4'h2
`define SGC_GAP_CYCLES     4'h1
`define SGC_ACCESS_CYCLES  4'h3
`endif

// ==== logic/sgc_pkg.sv ====
// Types for the supervisor RAM gate host controller.
package sgc_pkg;
  typedef enum logic [2:0] {
    SGC_IDLE,
    SGC_STROBE,
    SGC_GAP,
    SGC_RELEASE,
    SGC_ACCESS
  } sgc_state_t;

  typedef struct packed {
    sgc_state_t  state;
    logic [3:0]  timer;
    logic [1:0]  strobes;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        open;
    logic        top;
    logic [15:0] unlock;
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic        match_n;
    logic [7:0]  rdata;
    logic        done;
  } sgc_regs_t;
endpackage

// ==== logic/sgc_window_if.sv ====
// Window decode signals shared between the controller and its decoder.
`timescale 1ns/1ps
interface sgc_window_if;
  logic [15:0] addr;
  logic        top;
  logic        open;
  logic        in_window;
  logic        in_regs;
  logic        gate_ext;
  modport ctrl (output addr, output top, output open,
                input in_window, input in_regs, input gate_ext);
  modport dec  (input addr, input top, input open,
                output in_window, output in_regs, output gate_ext);
endinterface

// ==== logic/sgc_window_dec.sv ====
// Mirror of the gate's window decode, kept by the host controller.
`timescale 1ns/1ps
`include "sgc_cfg.svh"
module sgc_window_dec (
  sgc_window_if.dec win
);
  logic [15:0] base;

  always_comb begin
    base = win.top ? `SGC_WIN_TOP_BASE : `SGC_WIN_BOT_BASE;
    win.in_window = (win.addr & `SGC_WIN_MASK) == base;
    win.in_regs   = win.in_window && ((win.addr & `SGC_REG_MASK) == `SGC_REG_MASK);
    // The gate passes its enable outward except over the open window.
    win.gate_ext  = !(win.open && win.in_window);
  end
endmodule

// ==== tb/sgc_gate_model.sv ====
// Behavioural model of the supervisor RAM gate as the host sees it.
`timescale 1ns/1ps
module sgc_gate_model #(
  parameter logic [15:0] UNLOCK = 16'h07FF,
  parameter bit          TOP    = 1'b1
) (
  // Host side pins.
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        strobe_n,
  // Device outputs.
  output logic [7:0]       rdata,
  output logic             conditioned_enable_out_n
);
  logic [7:0]  mem [2048];
  logic [15:0] cap;
  logic [7:0]  last = 8'h00;
  logic        open_q = 1'b0;
  int          hits = 0;
  wire in_win = (addr[15:11] == (TOP ? 5'h1F : 5'h00));
  wire drive  = open_q && in_win && !ce_n && !oe_n;
  initial foreach (mem[i]) mem[i] = 8'h00;
  always @(negedge strobe_n) begin
    cap = addr;
    hits = (cap == UNLOCK) ? hits + 1 : 0;
  end
  always @(posedge ce_n or posedge strobe_n) if (hits >= 3 && ce_n) begin
    open_q = !open_q;
    hits = 0;
  end
  always @(posedge we_n) if (open_q && in_win && !ce_n) mem[addr[10:0]] = wdata;
  // A released bus shows the inverse of the last byte driven.
  always @(drive or addr) if (drive) last = mem[addr[10:0]];
  assign rdata    = drive ? mem[addr[10:0]] : ~last;
  assign conditioned_enable_out_n = (open_q && in_win) ? 1'b1 : ce_n;
endmodule

// ==== tb/sgc_host_tb.sv ====
// Self-checking bench for the supervisor RAM gate host controller.
`timescale 1ns/1ps
module sgc_host_tb;
  typedef struct {bit tg; bit wr; logic [15:0] a; logic [7:0] d;
    logic op; logic [7:0] rd; bit crd; logic ext; bit cext;} sgc_row_t;
  sgc_row_t    rows [11];
  logic        mclk = 0, nrst = 0, tg = 0, acc = 0, wr = 0, stu = 0, stp = 0, tpv = 1;
  logic [15:0] a = 16'h0000, stuv = 16'h07FF, addr;
  logic [7:0]  wd = 8'h00, rdata, dout, din;
  logic        ready, done, wopen, refused, doe, ce_n, we_n, oe_n, strb, ccon, ext;
  int          fails = 0, compares = 0;
  sgc_host i_sgc_host (.MCLK(mclk), .NRST(nrst), .REQ_TOGGLE(tg), .REQ_ACCESS(acc),
    .REQ_WRITE(wr), .REQ_ADDR(a), .REQ_WDATA(wd), .SET_TOP(stp), .SET_TOP_VAL(tpv),
    .SET_UNLOCK(stu), .SET_UNLOCK_VAL(stuv), .READY(ready), .DONE(done), .RDATA(rdata),
    .WINDOW_OPEN(wopen), .REFUSED(refused), .ADDR(addr), .DATA_OUT(dout), .DATA_OE(doe),
    .DATA_IN(din), .CE_N(ce_n), .WE_N(we_n), .OE_N(oe_n), .UNLOCK_MATCH_STROBE(strb),
    .CONDITIONED_ENABLE_OUT_N(ccon), .EXT_SELECT_N(ext));
  sgc_gate_model i_sgc_gate_model (.addr(addr), .wdata(dout), .ce_n(ce_n), .we_n(we_n),
    .oe_n(oe_n), .strobe_n(strb), .rdata(din), .conditioned_enable_out_n(ccon));
  always #12.5 mclk = ~mclk;
  task results;
    if (fails == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task op(input sgc_row_t r);
    int n;
    logic e;
    logic rf;
    e = 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 50) begin
      @(posedge mclk);
      #2;
      n++;
    end
    if (ready !== 1'b1) begin fails++; results(); end
    tg = r.tg;
    acc = !r.tg;
    wr = r.wr;
    a = r.a;
    wd = r.d;
    @(posedge mclk);
    #2;
    tg = 0;
    acc = 0;
    n = 0;
    while (done !== 1'b1 && n < 50) begin
      @(posedge mclk);
      #2;
      if (ce_n === 1'b0) e = ext;
      n++;
    end
    if (done !== 1'b1) begin fails++; results(); end
    rf = !r.tg && (r.a[15:11] == (tpv ? 5'h1F : 5'h00)) && !r.op;
    chk("open", {15'h0, r.op}, {15'h0, wopen});
    if (r.crd) chk("rdata", {8'h00, r.rd}, {8'h00, rdata});
    if (r.cext) chk("ext_select", {15'h0, r.ext}, {15'h0, e});
    chk("refused", {15'h0, rf}, {15'h0, refused});
  endtask
  task set_unlock(input logic [15:0] v);
    stu = 1;
    stuv = v;
    @(posedge mclk);
    #2;
    stu = 0;
  endtask
  initial begin
    rows = '{
      '{0, 1, 16'hF801, 8'h11, 0, 8'h00, 0, 0, 1},
      '{1, 0, 16'h0000, 8'h00, 1, 8'h00, 0, 0, 0},
      '{0, 1, 16'hF800, 8'hA5, 1, 8'h00, 0, 1, 1},
      '{0, 1, 16'hFFF8, 8'h3C, 1, 8'h00, 0, 1, 1},
      '{0, 0, 16'hF800, 8'h00, 1, 8'hA5, 1, 1, 1},
      '{0, 0, 16'hF801, 8'h00, 1, 8'h00, 1, 1, 1},
      '{0, 0, 16'hFFF8, 8'h00, 1, 8'h3C, 1, 1, 1},
      '{0, 0, 16'hE000, 8'h00, 1, 8'h00, 0, 0, 1},
      '{1, 0, 16'h0000, 8'h00, 0, 8'h00, 0, 0, 0},
      '{0, 0, 16'hF800, 8'h00, 0, 8'h00, 0, 0, 1},
      '{1, 0, 16'h0000, 8'h00, 1, 8'h00, 0, 0, 0}};
    repeat (10) @(posedge mclk);
    #2;
    nrst = 1;
    chk("open_reset", 16'h0000, {15'h0, wopen});
    foreach (rows[i]) op(rows[i]);
    op(rows[4]);
    // A wrong unlock address must leave the gate as it was.
    set_unlock(16'h0123);
    op(rows[8]);
    chk("gate_open", 16'h0001, {15'h0, i_sgc_gate_model.open_q});
    // Move the host's window to the bottom block and access it while closed.
    stp = 1;
    tpv = 0;
    @(posedge mclk);
    #2;
    stp = 0;
    op(sgc_row_t'{0, 0, 16'h0010, 8'h00, 0, 8'h00, 0, 0, 1});
    set_unlock(16'h07FF);
    nrst = 0;
    @(posedge mclk);
    #2;
    chk("open_rst2", 16'h0000, {15'h0, wopen});
    chk("ce_rst2", 16'h0001, {15'h0, ce_n});
    nrst = 1;
    @(posedge mclk);
    #2;
    chk("ready_rst2", 16'h0001, {15'h0, ready});
    chk("done_rst2", 16'h0000, {15'h0, done});
    results();
  end
endmodule
